//--- verilog/otp_defines.svh
/*
  Command codes, OTP map positions and register field positions for the
  OTP, identification and register command block.
  Assumes it is included by its bare name and that nothing else defines these.
*/
`ifndef OTP_DEFINES_SVH
`define OTP_DEFINES_SVH

// Command codes
`define CMD_WRITE_REGS     8'h01
`define CMD_WRITE_DISABLE  8'h04
`define CMD_READ_STATUS    8'h05
`define CMD_WRITE_ENABLE   8'h06
`define CMD_CLEAR_STATUS   8'h30
`define CMD_READ_CONFIG    8'h35
`define CMD_LEARN_READ     8'h41
`define CMD_OTP_PROG       8'h42
`define CMD_LEARN_PROG_NV  8'h43
`define CMD_LEARN_WRITE_V  8'h4a
`define CMD_OTP_READ       8'h4b
`define CMD_ID_READ        8'h9f

// OTP space geometry
`define OTP_BYTES          1024
`define OTP_ADDR_W         10
`define OTP_REGIONS        32
`define OTP_REGION_BYTES   32
`define OTP_RANDOM_LAST    10'h00f
`define OTP_LOCK_BASE      10'h010
`define OTP_LOCK_LAST      10'h013
`define OTP_SPARE_FIRST    10'h014
`define OTP_SPARE_LAST     10'h01f
`define OTP_ERASED         8'hff

// Identification space size
`define ID_BYTES           16

// status_one field positions
`define STATUS_ONE_BUSY      0
`define STATUS_ONE_LATCH     1
`define STATUS_ONE_BP_LO     2
`define STATUS_ONE_ERASE_ERR 5
`define STATUS_ONE_PROG_ERR  6
`define STATUS_ONE_WR_LOCK   7

// configuration_one field positions and reset value
`define CONFIG_ONE_FREEZE  0
`define CONFIG_ONE_RESET   8'h00

// Learning pattern delivery value
`define LEARN_DELIVERY     8'h00

`endif

//--- verilog/otp_pkg.sv
/*
  Types shared by the OTP command block.
  Assumes the defines header is compiled alongside.
*/
package otp_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_LOCK_RD,
    ST_LOCK_CHK,
    ST_DATA_RD,
    ST_DATA_WR,
    ST_OTP_RD,
    ST_OTP_RSP,
    ST_ID_RD,
    ST_ID_RSP
  } otp_state_t;

endpackage

//--- verilog/otp_mem.sv
/*
  OTP byte store: 1024 bytes, one write port, registered read data.
  Assumes the controller only ever writes the old value ANDed with new data.
  Contents are never touched by reset, so programmed bytes survive it.
*/
`include "otp_defines.svh"

module otp_mem #(
  parameter int           DEPTH      = `OTP_BYTES,
  parameter int           AW         = `OTP_ADDR_W,
  // Arbitrary factory random number, least significant byte at address 0
  parameter logic [127:0] RANDOM_VAL = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
) (
  // Clock
  input  wire logic          clk_in,
  // Access
  input  wire logic          we_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [7:0]    wdata_in,
  output logic      [7:0]    rdata_out
);

  typedef logic [7:0] mem_array_t [DEPTH];

  // Delivery state: random number in bytes 0..15, everything else erased
  function automatic mem_array_t delivery_image();
    for (int i = 0; i < DEPTH; i++) begin
      delivery_image[i] = `OTP_ERASED;
    end
    for (int i = 0; i < 16; i++) begin
      delivery_image[i] = RANDOM_VAL[i*8 +: 8];
    end
  endfunction

  // Set by declaration so the write port stays the only process driving it
  mem_array_t mem = delivery_image();

  // Write port
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  // Registered read, one cycle behind the address
  always_ff @(posedge clk_in) begin
    rdata_out <= mem[addr_in];
  end

endmodule

//--- verilog/id_cfi_rom.sv
/*
  Identification and CFI space: fixed factory bytes, no write port at all.
  Assumes the address is a byte index; beyond the table reads as zero.
*/
`include "otp_defines.svh"

module id_cfi_rom #(
  parameter int                  DEPTH   = `ID_BYTES,
  parameter int                  AW      = `OTP_ADDR_W,
  // Arbitrary identification bytes, byte 0 in the low bits
  parameter logic [DEPTH*8-1:0]  CONTENT = 128'h00_00_00_00_11_22_33_44_59_52_51_4d_10_02_20_a5
) (
  // Clock
  input  wire logic          clk_in,
  // Read access
  input  wire logic [AW-1:0] addr_in,
  output logic      [7:0]    rdata_out
);

  // Registered lookup
  always_ff @(posedge clk_in) begin
    if (int'(addr_in) < DEPTH) begin
      rdata_out <= CONTENT[addr_in*8 +: 8];
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule

//--- verilog/otp_space_ctrl.sv
/*
  Command-level controller for the OTP space, the identification space and
  the status, configuration and learning pattern registers.
  Assumes a host-side serial front end already decoded each command into a
  one-cycle strobe with code, byte address and up to two data bytes, and that
  it only strobes while busy_out is low.
*/
//
// Behaviour
// R1 - Identification read command returns bytes from separate identification space.
// R2 - Identification space is fixed; no command can change it.
// R3 - OTP space holds 1024 bytes apart from the main array.
// R4 - OTP has 32 regions of 32 aligned bytes, each lockable alone.
// R5 - Bytes 000-00F hold factory random number; host programming refused.
// R6 - Bytes 010-013 hold one lock bit per region; 0 means locked.
// R7 - Programming a lock bit permanently blocks programming of its region.
// R8 - Reserved bytes 014-01F accept programming; host should not rely on them.
// R9 - Everything except random number is delivered erased to all ones.
// R10 - Freeze bit set rejects every OTP program regardless of lock bits.
// R11 - Boot code programs OTP first, then sets freeze for the session.
// R12 - Registers reached only by their own command codes, never addresses.
// R13 - Volatile bits return to defaults on any reset.
// R14 - Non-volatile and OTP bits keep programmed values across resets.
// R15 - Learning pattern exists as stored and active 8-bit registers.
// R16 - Program into locked region sets program error until clear status.
// R17 - OTP program ignored unless write enable latch was set first.
// R18 - OTP programming only clears bits; nothing sets them back.
`include "otp_defines.svh"

module otp_space_ctrl
  import otp_pkg::*;
#(
  parameter int AW = `OTP_ADDR_W
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  // Decoded command
  input  wire logic          cmd_valid_in,
  input  wire logic [7:0]    cmd_code_in,
  input  wire logic [AW-1:0] cmd_addr_in,
  input  wire logic [7:0]    cmd_data_in,
  input  wire logic [7:0]    cmd_data_hi_in,
  // Answer
  output logic               rsp_valid_out,
  output logic      [7:0]    rsp_data_out,
  // Status
  output logic               busy_out,
  output logic      [7:0]    status_one_out,
  output logic      [7:0]    configuration_one_out
);

  // Region number of an OTP byte address
  function automatic logic [4:0] region_of(input logic [AW-1:0] a);
    region_of = a[AW-1:AW-5];
  endfunction

  otp_state_t    state_q;
  logic          busy_q;
  logic [AW-1:0] addr_q;
  byte_t         data_q;
  logic          write_enable_latch_q;
  logic          p_err_q;
  logic          srwd_q;
  logic [2:0]    bp_q;
  byte_t         configuration_one_q;
  byte_t         learning_pattern_active_q;
  byte_t         learning_pattern_stored_q = `LEARN_DELIVERY;
  logic          learn_load_q;
  logic          rsp_valid_q;
  byte_t         rsp_data_q;

  logic          take;
  logic          freeze;
  logic [4:0]    region;
  logic          prog_refused;
  logic [AW-1:0] mem_addr;
  logic          mem_we;
  byte_t         mem_wdata;
  byte_t         mem_rdata;
  byte_t         rom_rdata;
  byte_t         status_one;

  // A command is taken only while idle; strobes during work are dropped
  assign take   = cmd_valid_in && (state_q == ST_IDLE);
  assign freeze = configuration_one_q[`CONFIG_ONE_FREEZE];
  assign region = region_of(addr_q);

  // Erase error never occurs here: no erase path in this block
  assign status_one = {srwd_q, p_err_q, 1'b0, bp_q, write_enable_latch_q, busy_q};

  // Refusal decided when the lock byte comes back
  always_comb begin
    prog_refused = 1'b0;
    if (freeze) begin
      prog_refused = 1'b1;                              // R10
    end
    if (addr_q <= `OTP_RANDOM_LAST) begin
      prog_refused = 1'b1;                              // R5
    end
    if (!mem_rdata[region[2:0]]) begin
      prog_refused = 1'b1;                              // R6 R7
    end
  end

  // Memory address: lock byte in ST_LOCK_RD, else the latched address
  always_comb begin
    if (state_q == ST_LOCK_RD) begin
      mem_addr = AW'(`OTP_LOCK_BASE) + AW'(region[4:3]); // R4 R6
    end else begin
      mem_addr = addr_q;
    end
  end

  // Only ever clears bits, so nothing in this block sets a bit back to one
  assign mem_we    = (state_q == ST_DATA_WR);
  assign mem_wdata = mem_rdata & data_q;                // R18

  // OTP byte store, separate from any main array
  otp_mem #(
    .DEPTH      (`OTP_BYTES),
    .AW         (AW)
  ) u_otp_mem (                                         // R3 R9 R14
    .clk_in     (clk_in),
    .we_in      (mem_we),
    .addr_in    (mem_addr),
    .wdata_in   (mem_wdata),
    .rdata_out  (mem_rdata)
  );

  // Identification space has no write port
  id_cfi_rom #(
    .DEPTH      (`ID_BYTES),
    .AW         (AW)
  ) u_id_cfi_rom (                                      // R2
    .clk_in     (clk_in),
    .addr_in    (addr_q),
    .rdata_out  (rom_rdata)
  );

  // Sequencer for OTP program, OTP read and identification read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
      addr_q  <= '0;
      data_q  <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            case (cmd_code_in)
              `CMD_OTP_PROG: begin
                if (write_enable_latch_q) begin         // R17
                  state_q <= ST_LOCK_RD;
                  busy_q  <= 1'b1;
                  addr_q  <= cmd_addr_in;
                  data_q  <= cmd_data_in;
                end
              end
              `CMD_OTP_READ: begin
                state_q <= ST_OTP_RD;
                busy_q  <= 1'b1;
                addr_q  <= cmd_addr_in;
              end
              `CMD_ID_READ: begin
                state_q <= ST_ID_RD;                    // R1
                busy_q  <= 1'b1;
                addr_q  <= cmd_addr_in;
              end
              default: begin
              end
            endcase
          end
        end
        ST_LOCK_RD:  state_q <= ST_LOCK_CHK;
        ST_LOCK_CHK: begin
          if (prog_refused) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end else begin
            state_q <= ST_DATA_RD;                      // R8
          end
        end
        ST_DATA_RD:  state_q <= ST_DATA_WR;
        ST_DATA_WR: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
        ST_OTP_RD:   state_q <= ST_OTP_RSP;
        ST_ID_RD:    state_q <= ST_ID_RSP;
        ST_OTP_RSP, ST_ID_RSP: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // Write enable latch: set and cleared by command, spent by success
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      write_enable_latch_q <= 1'b0;                     // R13
    end else if (state_q == ST_DATA_WR) begin
      write_enable_latch_q <= 1'b0;
    end else if (take) begin
      case (cmd_code_in)
        `CMD_WRITE_ENABLE:  write_enable_latch_q <= 1'b1;
        `CMD_WRITE_DISABLE: write_enable_latch_q <= 1'b0;
        `CMD_WRITE_REGS, `CMD_LEARN_PROG_NV, `CMD_LEARN_WRITE_V: write_enable_latch_q <= 1'b0;
        default:            write_enable_latch_q <= write_enable_latch_q;
      endcase
    end
  end

  // Program error: a refusal wins over a clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      p_err_q <= 1'b0;
    end else if (state_q == ST_LOCK_CHK && prog_refused) begin
      p_err_q <= 1'b1;                                  // R16
    end else if (take && cmd_code_in == `CMD_CLEAR_STATUS) begin
      p_err_q <= 1'b0;                                  // R16
    end
  end

  // Status and configuration writes, gated by the latch
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      srwd_q              <= 1'b0;                      // R13
      bp_q                <= 3'h0;
      configuration_one_q <= `CONFIG_ONE_RESET;
    end else if (take && cmd_code_in == `CMD_WRITE_REGS && write_enable_latch_q) begin
      srwd_q              <= cmd_data_in[`STATUS_ONE_WR_LOCK]; // R12
      bp_q                <= cmd_data_in[`STATUS_ONE_BP_LO +: 3];
      // Freeze can be set but never cleared until the next reset
      configuration_one_q <= {cmd_data_hi_in[7:1], freeze | cmd_data_hi_in[`CONFIG_ONE_FREEZE]}; // R10
    end
  end

  // Stored pattern has no reset so it survives every reset
  always_ff @(posedge clk_in) begin
    if (take && cmd_code_in == `CMD_LEARN_PROG_NV && write_enable_latch_q) begin
      learning_pattern_stored_q <= cmd_data_in;         // R14 R15
    end
  end

  // Active pattern is copied from the stored one just after reset release
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      learn_load_q              <= 1'b1;
      learning_pattern_active_q <= 8'h00;               // R13
    end else if (learn_load_q) begin
      learn_load_q              <= 1'b0;
      learning_pattern_active_q <= learning_pattern_stored_q; // R15
    end else if (take && cmd_code_in == `CMD_LEARN_WRITE_V && write_enable_latch_q) begin
      learning_pattern_active_q <= cmd_data_in;
    end
  end

  // Answers: register reads reply at once, space reads after the fetch
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
    end else begin
      rsp_valid_q <= 1'b0;
      if (take) begin
        case (cmd_code_in)
          `CMD_READ_STATUS: begin
            rsp_valid_q <= 1'b1;                        // R12
            rsp_data_q  <= status_one;
          end
          `CMD_READ_CONFIG: begin
            rsp_valid_q <= 1'b1;
            rsp_data_q  <= configuration_one_q;
          end
          `CMD_LEARN_READ: begin
            rsp_valid_q <= 1'b1;
            rsp_data_q  <= learning_pattern_active_q;
          end
          default: begin
          end
        endcase
      end else if (state_q == ST_OTP_RSP) begin
        rsp_valid_q <= 1'b1;
        rsp_data_q  <= mem_rdata;
      end else if (state_q == ST_ID_RSP) begin
        rsp_valid_q <= 1'b1;                            // R1
        rsp_data_q  <= rom_rdata;
      end
    end
  end

  // Outputs straight from flops
  assign rsp_valid_out         = rsp_valid_q;
  assign rsp_data_out          = rsp_data_q;
  assign busy_out              = busy_q;
  assign configuration_one_out = configuration_one_q;

  // Status mirror registered so the port never glitches
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_one_out <= 8'h00;
    end else begin
      status_one_out <= status_one;
    end
  end

endmodule

//--- tb/host_model.sv
/*
  Host side model: issues decoded flash commands, one at a time.
  Assumes a free running clock and a caller that uses run() only.
*/
module host_model (
  // Clock
  input  wire logic       clk_in,
  // Command
  output logic            cmd_valid_out,
  output logic      [7:0] cmd_code_out,
  output logic      [9:0] cmd_addr_out,
  output logic      [7:0] cmd_data_out,
  output logic      [7:0] cmd_data_hi_out,
  // Answer
  input  wire logic       rsp_valid_in,
  input  wire logic [7:0] rsp_data_in,
  input  wire logic       busy_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rsp;

  // Quiet command lines at start
  initial begin
    cmd_valid_out = 1'b0;
    {cmd_code_out, cmd_addr_out, cmd_data_out, cmd_data_hi_out} = '0;
  end

  // One command; released lines show inverted data, never the old request
  task automatic run(input logic [7:0] c, input logic [9:0] a = 10'h000,
                     input logic [7:0] d = 8'h00, input logic [7:0] h = 8'h00);
    int n;
    rsp = 8'hxx;
    @(negedge clk_in);
    {cmd_code_out, cmd_addr_out, cmd_data_out, cmd_data_hi_out} = {c, a, d, h};
    cmd_valid_out = 1'b1;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    {cmd_code_out, cmd_addr_out, cmd_data_out, cmd_data_hi_out} = ~{c, a, d, h};
    n = 0;
    while ((n < 6 || busy_in) && n < 40) begin
      if (rsp_valid_in) begin
        rsp = rsp_data_in;
      end
      @(negedge clk_in);
      n++;
    end
  endtask
endmodule

//--- tb/otp_space_ctrl_assertions.sv
/*
  Checker for the OTP command block, on its ports only.
  Assumes one clock, async high reset, and the bind at the foot.
*/
`include "otp_defines.svh"

module otp_space_ctrl_checker #(
  parameter int AW = `OTP_ADDR_W
) (
  // Clock and reset
  input wire logic          clk_in,
  input wire logic          rst_in,
  // Command
  input wire logic          cmd_valid_in,
  input wire logic [7:0]    cmd_code_in,
  input wire logic [AW-1:0] cmd_addr_in,
  input wire logic [7:0]    cmd_data_in,
  input wire logic [7:0]    cmd_data_hi_in,
  // Answer and status
  input wire logic          rsp_valid_out,
  input wire logic [7:0]    rsp_data_out,
  input wire logic          busy_out,
  input wire logic [7:0]    status_one_out,
  input wire logic [7:0]    configuration_one_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Clear command taken, for the error bit history
  logic clr_take;
  assign clr_take = cmd_valid_in && !busy_out && cmd_code_in == `CMD_CLEAR_STATUS;

  // Command takes; program only counts once the latch shows set
  sequence s_take(logic [7:0] c);
    cmd_valid_in && !busy_out && cmd_code_in == c;
  endsequence
  sequence s_prog;
    s_take(`CMD_OTP_PROG) ##0 status_one_out[1];
  endsequence

  reset_clear_a: assert property ($fell(rst_in) |->
    status_one_out == 8'h00 && configuration_one_out == 8'h00) else $error("reset state");
  id_answer_a: assert property (s_take(`CMD_ID_READ) |-> ##3 rsp_valid_out)
    else $error("id answer late");
  otp_read_a: assert property (s_take(`CMD_OTP_READ) |->
    ##1 busy_out [*2] ##1 (rsp_valid_out && !busy_out)) else $error("otp read walk");
  latch_set_a: assert property (s_take(`CMD_WRITE_ENABLE) |->
    ##[1:2] status_one_out[1]) else $error("latch not set");
  random_refuse_a: assert property (s_prog ##0 (cmd_addr_in <= `OTP_RANDOM_LAST) |->
    ##[1:6] status_one_out[6]) else $error("random write unflagged");
  freeze_refuse_a: assert property (s_prog ##0 configuration_one_out[0] |->
    ##[1:6] status_one_out[6]) else $error("frozen write unflagged");
  freeze_hold_a: assert property (configuration_one_out[0] |=>
    configuration_one_out[0]) else $error("freeze dropped");
  clear_err_a: assert property (s_take(`CMD_CLEAR_STATUS) |->
    ##[1:3] !status_one_out[6]) else $error("error not cleared");
  err_hold_a: assert property ($fell(status_one_out[6]) |->
    $past(clr_take) || $past(clr_take, 2) || $past(clr_take, 3) || $past(clr_take, 4))
    else $error("error dropped alone");
endmodule

bind otp_space_ctrl otp_space_ctrl_checker #(.AW(AW)) i_otp_space_ctrl_checker (
  .clk_in, .rst_in, .cmd_valid_in, .cmd_code_in, .cmd_addr_in, .cmd_data_in,
  .cmd_data_hi_in, .rsp_valid_out, .rsp_data_out, .busy_out, .status_one_out,
  .configuration_one_out);

//--- tb/otp_space_ctrl_tb.sv
/*
  Bench for the OTP command block, driven through the host model.
  Assumes the checker is bound from its own file.
*/
`include "otp_defines.svh"

module otp_space_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       cmd_valid_in, rsp_valid_out, busy_out;
  logic [9:0] cmd_addr_in;
  logic [7:0] cmd_code_in, cmd_data_in, cmd_data_hi_in;
  logic [7:0] rsp_data_out, status_one_out, configuration_one_out;
  int         err_count = 0;
  int         comparisons = 0;
  int         cycles = 0;

  // Design and host
  otp_space_ctrl i_otp_space_ctrl (.clk_in, .rst_in, .cmd_valid_in, .cmd_code_in,
    .cmd_addr_in, .cmd_data_in, .cmd_data_hi_in, .rsp_valid_out, .rsp_data_out,
    .busy_out, .status_one_out, .configuration_one_out);
  host_model i_host_model (.clk_in, .cmd_valid_out(cmd_valid_in),
    .cmd_code_out(cmd_code_in), .cmd_addr_out(cmd_addr_in), .cmd_data_out(cmd_data_in),
    .cmd_data_hi_out(cmd_data_hi_in), .rsp_valid_in(rsp_valid_out),
    .rsp_data_in(rsp_data_out), .busy_in(busy_out));

  // 50 MHz clock
  always #10 clk_in = ~clk_in;

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd(input string nm, input logic [7:0] c, input logic [9:0] a,
                    input logic [7:0] e);
    i_host_model.run(c, a);
    chk(nm, i_host_model.rsp, e);
  endtask

  task automatic perr(input logic [7:0] e);
    chk("prog_error", {7'h00, status_one_out[6]}, e);
  endtask

  // Program always preceded by write enable
  task automatic pg(input logic [9:0] a, input logic [7:0] d);
    i_host_model.run(`CMD_WRITE_ENABLE);
    i_host_model.run(`CMD_OTP_PROG, a, d);
  endtask

  task automatic do_reset();
    @(negedge clk_in);
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask

  // Identification bytes come from their own space
  task automatic t_ident();
    chk("status", status_one_out, 8'h00);
    rd("id0", `CMD_ID_READ, 10'h000, 8'ha5);
    rd("id16", `CMD_ID_READ, 10'h010, 8'h00);
    $display("test ident done");
  endtask

  // Delivery state: random number low byte first, rest erased
  task automatic t_fresh();
    rd("rnd0", `CMD_OTP_READ, 10'h000, 8'hf0);
    rd("rndf", `CMD_OTP_READ, 10'h00f, 8'h0f);
    rd("lock", `CMD_OTP_READ, 10'h013, 8'hff);
    rd("spare", `CMD_OTP_READ, 10'h01f, 8'hff);
    rd("top", `CMD_OTP_READ, 10'h3ff, 8'hff);
    $display("test fresh done");
  endtask

  // Needs the latch, only clears bits, drops the latch after
  task automatic t_prog();
    i_host_model.run(`CMD_OTP_PROG, 10'h020, 8'h00);
    rd("nolatch", `CMD_OTP_READ, 10'h020, 8'hff);
    perr(8'h00);
    pg(10'h020, 8'h5a);
    pg(10'h020, 8'hff);
    rd("prog", `CMD_OTP_READ, 10'h020, 8'h5a);
    chk("latch", {7'h00, status_one_out[1]}, 8'h00);
    $display("test prog done");
  endtask

  // Random bytes refused; error flag stays until cleared
  task automatic t_refuse();
    pg(10'h000, 8'h00);
    perr(8'h01);
    rd("status_rd", `CMD_READ_STATUS, 10'h000, 8'h42);
    rd("rnd", `CMD_OTP_READ, 10'h000, 8'hf0);
    i_host_model.run(`CMD_CLEAR_STATUS);
    perr(8'h00);
    i_host_model.run(`CMD_WRITE_DISABLE);
    $display("test refuse done");
  endtask

  // Region 1 locked at its last byte; region 2 and spare bytes open
  task automatic t_lock();
    pg(10'h010, 8'hfd);
    pg(10'h03f, 8'h00);
    perr(8'h01);
    rd("locked", `CMD_OTP_READ, 10'h03f, 8'hff);
    i_host_model.run(`CMD_CLEAR_STATUS);
    pg(10'h040, 8'h12);
    rd("open", `CMD_OTP_READ, 10'h040, 8'h12);
    pg(10'h014, 8'h0f);
    rd("spare", `CMD_OTP_READ, 10'h014, 8'h0f);
    $display("test lock done");
  endtask

  // Freeze set after programming blocks every OTP write
  task automatic t_freeze();
    i_host_model.run(`CMD_WRITE_ENABLE);
    i_host_model.run(`CMD_WRITE_REGS, 10'h000, 8'h1c, 8'h01);
    chk("freeze", configuration_one_out, 8'h01);
    rd("status_wr", `CMD_READ_STATUS, 10'h000, 8'h1c);
    rd("config_rd", `CMD_READ_CONFIG, 10'h000, 8'h01);
    pg(10'h060, 8'h00);
    perr(8'h01);
    rd("frozen", `CMD_OTP_READ, 10'h060, 8'hff);
    i_host_model.run(`CMD_WRITE_REGS, 10'h000, 8'h1c, 8'h00);
    chk("freeze_kept", configuration_one_out, 8'h01);
    $display("test freeze done");
  endtask

  // Reset clears volatile state, keeps OTP and stored pattern
  task automatic t_learn();
    i_host_model.run(`CMD_WRITE_ENABLE);
    i_host_model.run(`CMD_LEARN_WRITE_V, 10'h000, 8'h3c);
    rd("act", `CMD_LEARN_READ, 10'h000, 8'h3c);
    i_host_model.run(`CMD_WRITE_ENABLE);
    i_host_model.run(`CMD_LEARN_PROG_NV, 10'h000, 8'h77);
    rd("act2", `CMD_LEARN_READ, 10'h000, 8'h3c);
    do_reset();
    chk("config", configuration_one_out, 8'h00);
    perr(8'h00);
    chk("status_rst", status_one_out, 8'h00);
    rd("stored", `CMD_LEARN_READ, 10'h000, 8'h77);
    rd("kept", `CMD_OTP_READ, 10'h010, 8'hfd);
    $display("test learn done");
  endtask

  // Main sequence
  initial begin
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    t_ident();
    t_fresh();
    t_prog();
    t_refuse();
    t_lock();
    t_freeze();
    t_learn();
    summarize();
  end
endmodule
